// *** boot_control.sv ***
`timescale 1ns/1ps
`include "boot_defines.svh"
// Summary of operation
// - Map bit set sends external-data moves to program RAM, clear to data RAM.
// - Map bit overrides the external RAM select bit.
// - Map control register resets map bit to 0; reserved bits unused, read 0.
// - Configuration byte bit 6 chooses customer program or bootloader after reset.
// - Bootloader lives at C000h to FFFFh and is entered at F800h.
// - External source: copy to EEPROM and program RAM; else EEPROM to RAM.
// - After loading, jump so the program counter starts at 0000h.
// - Image top bytes: security byte 3FFDh, CRC bytes 3FFEh and 3FFFh.
// - CRC over image, judged only once all 16K bytes are written.
// - Host mode reports Y on pass, Z on fail, then CR LF.
// - Download mode failure sends AA on port 3 bit 7, no execution.
// - Internal EEPROM copy takes about 4 s at 100 MHz.
// - Level 3 with both lock bits disables reads, keeps checksum.
// - Level 3 blocks code moves from external memory; access pin latched.
// - CRC reflected poly 8408h, init FFFFh, inverted, low byte first.
module boot_control #(
   parameter int COPY_CYCLES = `COPY_CYCLES
) (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   // Special function register port
   input  wire logic [7:0]  sfrAddr,
   input  wire logic        sfrWr,
   input  wire logic [7:0]  sfrWrData,
   output logic [7:0]       sfrRdData_r,
   // Straps
   input  wire logic [7:0]  cfgByte,
   input  wire logic        lockBitOne,
   input  wire logic        lockBitTwo,
   input  wire logic        externalAccessPin,
   input  wire logic        hostProgMode,
   input  wire logic        extSourceDetected,
   // External data moves
   input  wire logic        movxReq,
   input  wire logic        extRamSel,
   output logic             movxToProgRam_r,
   output logic             movxToXram_r,
   output logic             movxToExternal_r,
   // Code moves and program reads
   input  wire logic        codeMoveReq,
   input  wire logic        codeMoveFromExt,
   input  wire logic        progReadReq,
   output logic             codeMoveBlocked_r,
   output logic             progReadDenied_r,
   output logic             extAccessLatched_r,
   // Image stream from external source
   input  wire logic        srcValid,
   input  wire logic [7:0]  srcData,
   output logic             srcReady_r,
   // Internal EEPROM
   output logic             eepRd_r,
   output logic             eepWe_r,
   output logic [13:0]      eepAddr_r,
   output logic [7:0]       eepWrData_r,
   input  wire logic        eepRdValid,
   input  wire logic [7:0]  eepRdData,
   input  wire logic        eepBusy,
   // Program RAM write
   output logic             pramWe_r,
   output logic [13:0]      pramAddr_r,
   output logic [7:0]       pramData_r,
   // Program counter load
   output logic             pcLoad_r,
   output logic [15:0]      pcValue_r,
   // Host reply and error pin
   output logic             hostTxValid_r,
   output logic [7:0]       hostTxData_r,
   input  wire logic        hostTxReady,
   output logic             port3Bit7Out_r,
   output logic             port3Bit7Oe_n_r,
   output logic             bootFail_r
);
   logic                      rstMeta_r;
   logic                      rstN;
   boot_pkg::boot_state_t     state_r;
   boot_pkg::boot_state_t     state_nxt;
   logic                      mapBit_r;
   logic                      bootSel_r;
   logic                      extMode_r;
   logic [14:0]               rdCnt_r;
   logic [14:0]               wrCnt_r;
   logic                      rdPend_r;
   logic [15:0]               crc_r;
   logic                      crcPass_r;
   logic [31:0]               copyTimer_r;
   logic [1:0]                repIdx_r;
   logic [3:0]                errBit_r;
   logic [7:0]                errTick_r;

   // Reset release through two stages
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rstMeta_r <= 1'b0;
         rstN      <= 1'b0;
      end
      else
      begin
         rstMeta_r <= 1'b1;
         rstN      <= rstMeta_r;
      end
   end

   // One step of the reflected CRC per byte
   function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] w;
      w = c ^ {8'h00, d};
      for (int i = 0; i < 8; i++)
         w = w[0] ? ((w >> 1) ^ `CRC_POLY) : (w >> 1);
      return w;
   endfunction

   wire        loading    = state_r == boot_pkg::ST_LOAD;
   wire        loadExt    = loading && extMode_r;
   wire        lockLevel3 = lockBitOne && lockBitTwo;
   wire        fifoInValid = loadExt ? (srcValid && srcReady_r) : eepRdValid;
   wire [7:0]  fifoInData  = loadExt ? srcData : eepRdData;
   wire        fifoRoom;
   wire        fifoOutValid;
   wire [7:0]  fifoOutData;
   wire        drainOk    = loading && !(extMode_r && eepBusy);
   wire        pop        = fifoOutValid && drainOk;
   wire        issueRd    = loading && !extMode_r && !rdPend_r && fifoRoom
                            && rdCnt_r != `IMG_BYTES && !eepRd_r;
   wire        imageDone  = wrCnt_r == `IMG_BYTES;
   wire        copyLate   = !extMode_r && copyTimer_r == 32'(COPY_CYCLES);
   wire        crcOk      = crc_r == `CRC_RESIDUE;
   wire [7:0]  errCode    = `ERR_CODE;
   wire        mapHit     = sfrAddr == `MAP_CTRL_ADDR;
   wire        errTickEnd = errTick_r == `ERR_BIT_CYCLES - 8'h01;
   wire [7:0]  repChar    = repIdx_r == 2'd0 ? (crcPass_r ? `CHAR_PASS : `CHAR_FAIL)
                          : repIdx_r == 2'd1 ? `CHAR_CR : `CHAR_LF;

   byte_fifo #(
      .WIDTH (`FIFO_WIDTH),
      .DEPTH (`FIFO_DEPTH)
   ) u_fifo (
      .clk      (core_clk),
      .rstN     (rstN),
      .inValid  (fifoInValid),
      .inData   (fifoInData),
      .inReady  (),
      .roomTwo  (fifoRoom),
      .outValid (fifoOutValid),
      .outData  (fifoOutData),
      .outReady (drainOk)
   );

   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         boot_pkg::ST_STRAP:  state_nxt = cfgByte[`BOOT_SEL_BIT] ? boot_pkg::ST_ROMRUN
                                                                  : boot_pkg::ST_LOAD;
         boot_pkg::ST_LOAD:   state_nxt = copyLate ? boot_pkg::ST_HALT
                                        : imageDone ? boot_pkg::ST_CHECK : state_r;
         boot_pkg::ST_CHECK:  state_nxt = hostProgMode ? boot_pkg::ST_REPORT
                                        : crcOk ? boot_pkg::ST_JUMP : boot_pkg::ST_ERRSIG;
         boot_pkg::ST_REPORT: if (hostTxValid_r && hostTxReady && repIdx_r == 2'd2)
                                 state_nxt = crcPass_r ? boot_pkg::ST_JUMP : boot_pkg::ST_HALT;
         boot_pkg::ST_ERRSIG: if (errTickEnd && errBit_r == 4'd8)
                                 state_nxt = boot_pkg::ST_HALT;
         boot_pkg::ST_JUMP:   state_nxt = boot_pkg::ST_RUN;
         boot_pkg::ST_ROMRUN: state_nxt = state_r;
         boot_pkg::ST_RUN:    state_nxt = state_r;
         boot_pkg::ST_HALT:   state_nxt = state_r;
         default:             state_nxt = boot_pkg::ST_HALT;
      endcase
   end

   // Straps, memory map and protection
   always_ff @(posedge core_clk or negedge rstN)
   begin
      if (!rstN)
      begin
         state_r            <= boot_pkg::ST_STRAP;
         mapBit_r           <= 1'b0;
         bootSel_r          <= 1'b0;
         extMode_r          <= 1'b0;
         extAccessLatched_r <= 1'b0;
         sfrRdData_r        <= `MAP_CTRL_RESET;
         movxToProgRam_r    <= 1'b0;
         movxToXram_r       <= 1'b0;
         movxToExternal_r   <= 1'b0;
         codeMoveBlocked_r  <= 1'b0;
         progReadDenied_r   <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         if (state_r == boot_pkg::ST_STRAP)
         begin
            bootSel_r          <= cfgByte[`BOOT_SEL_BIT];
            extMode_r          <= extSourceDetected;
            // access pin caught at reset release
            extAccessLatched_r <= externalAccessPin;
         end
         if (sfrWr && mapHit)
            mapBit_r <= sfrWrData[`MAP_BIT];
         sfrRdData_r <= mapHit ? {4'h0, mapBit_r, 3'b000} : 8'h00;
         movxToProgRam_r  <= movxReq && mapBit_r;
         movxToXram_r     <= movxReq && !mapBit_r && !extRamSel;
         movxToExternal_r <= movxReq && !mapBit_r && extRamSel;
         // level 3 blocks external code moves
         codeMoveBlocked_r <= codeMoveReq && codeMoveFromExt && lockLevel3;
         progReadDenied_r  <= progReadReq && lockLevel3;
      end
   end

   // Loader datapath
   always_ff @(posedge core_clk or negedge rstN)
   begin
      if (!rstN)
      begin
         rdCnt_r     <= '0;
         wrCnt_r     <= '0;
         rdPend_r    <= 1'b0;
         eepRd_r     <= 1'b0;
         eepWe_r     <= 1'b0;
         eepAddr_r   <= '0;
         eepWrData_r <= '0;
         pramWe_r    <= 1'b0;
         pramAddr_r  <= '0;
         pramData_r  <= '0;
         srcReady_r  <= 1'b0;
         crc_r       <= `CRC_INIT;
         crcPass_r   <= 1'b0;
         copyTimer_r <= '0;
      end
      else
      begin
         // Lagging ready is safe: room for two is asked
         srcReady_r <= loadExt && fifoRoom && !imageDone;
         eepRd_r    <= issueRd;
         if (issueRd)
         begin
            eepAddr_r <= rdCnt_r[13:0];
            rdCnt_r   <= rdCnt_r + 15'd1;
            rdPend_r  <= 1'b1;
         end
         else if (eepRdValid)
            rdPend_r <= 1'b0;
         // copy to program RAM, mirror to EEPROM when loading from the external source
         pramWe_r <= pop;
         eepWe_r  <= pop && extMode_r;
         if (pop)
         begin
            pramAddr_r  <= wrCnt_r[13:0];
            pramData_r  <= fifoOutData;
            eepWrData_r <= fifoOutData;
            if (extMode_r)
               eepAddr_r <= wrCnt_r[13:0];
            wrCnt_r <= wrCnt_r + 15'd1;
            crc_r   <= crcByte(crc_r, fifoOutData);
         end
         // stored CRC folds into a fixed residue
         if (state_r == boot_pkg::ST_CHECK)
            crcPass_r <= crc_r == `CRC_RESIDUE;
         if (loading && !extMode_r)
            copyTimer_r <= copyTimer_r + 32'd1;
      end
   end

   // Jump, host reply and error pin
   always_ff @(posedge core_clk or negedge rstN)
   begin
      if (!rstN)
      begin
         pcLoad_r        <= 1'b0;
         pcValue_r       <= `BOOT_ENTRY;
         hostTxValid_r   <= 1'b0;
         hostTxData_r    <= '0;
         repIdx_r        <= '0;
         port3Bit7Out_r  <= 1'b1;
         port3Bit7Oe_n_r <= 1'b1;
         errBit_r        <= '0;
         errTick_r       <= '0;
         bootFail_r      <= 1'b0;
      end
      else
      begin
         pcLoad_r <= 1'b0;
         if (state_r == boot_pkg::ST_STRAP)
         begin
            pcLoad_r <= 1'b1;
            pcValue_r <= cfgByte[`BOOT_SEL_BIT] ? `APP_ENTRY : `BOOT_ENTRY;
         end
         // long jump to start of program RAM
         // only a passing check reaches here
         if (state_r == boot_pkg::ST_JUMP)
         begin
            pcLoad_r  <= 1'b1;
            pcValue_r <= `APP_ENTRY;
         end
         // Y or Z then CR LF
         if (state_r == boot_pkg::ST_REPORT)
         begin
            hostTxValid_r <= 1'b1;
            hostTxData_r  <= repChar;
            if (hostTxValid_r && hostTxReady)
            begin
               hostTxValid_r <= repIdx_r != 2'd2;
               hostTxData_r  <= repIdx_r == 2'd0 ? `CHAR_CR : `CHAR_LF;
               repIdx_r      <= repIdx_r + 2'd1;
            end
         end
         // shift AA out, LSB first, framed by idle high
         if (state_r == boot_pkg::ST_ERRSIG)
         begin
            port3Bit7Oe_n_r <= 1'b0;
            port3Bit7Out_r  <= errBit_r == 4'd8 ? 1'b1 : errCode[errBit_r[2:0]];
            errTick_r       <= errTickEnd ? 8'h00 : errTick_r + 8'h01;
            if (errTickEnd)
               errBit_r <= errBit_r + 4'd1;
         end
         if (state_nxt == boot_pkg::ST_HALT)
            bootFail_r <= 1'b1;
      end
   end

   sequence s_fail_check;
      state_r == boot_pkg::ST_CHECK && crc_r != `CRC_RESIDUE;
   endsequence

   property p_external_data_move_instr_ram;
      @(posedge core_clk) disable iff (!rstN) movxReq && mapBit_r |=> movxToProgRam_r;
   endproperty
   a_external_data_move_instr_ram: assert property (p_external_data_move_instr_ram) else $error("map bit ignored");

   property p_map_prio;
      @(posedge core_clk) disable iff (!rstN)
         movxReq && mapBit_r && extRamSel |=> !movxToExternal_r && !movxToXram_r;
   endproperty
   a_map_prio: assert property (p_map_prio) else $error("select beat map bit");

   property p_map_reset;
      @(posedge core_clk) $rose(rstN) |-> !mapBit_r;
   endproperty
   a_map_reset: assert property (p_map_reset) else $error("map bit not reset");

   property p_entry;
      @(posedge core_clk) disable iff (!rstN)
         state_r == boot_pkg::ST_STRAP && !cfgByte[`BOOT_SEL_BIT]
         |=> pcLoad_r && pcValue_r == 16'hF800 && state_r == boot_pkg::ST_LOAD;
   endproperty
   a_entry: assert property (p_entry) else $error("bad bootloader entry");

   property p_jump;
      @(posedge core_clk) disable iff (!rstN)
         state_r == boot_pkg::ST_JUMP |=> pcLoad_r && pcValue_r == 16'h0000;
   endproperty
   a_jump: assert property (p_jump) else $error("jump not to zero");

   property p_check_full;
      @(posedge core_clk) disable iff (!rstN)
         state_r == boot_pkg::ST_CHECK |-> wrCnt_r == 15'h4000;
   endproperty
   a_check_full: assert property (p_check_full) else $error("early check");

   property p_reply;
      @(posedge core_clk) disable iff (!rstN)
         s_fail_check ##0 hostProgMode ##2 hostTxValid_r |-> hostTxData_r == 8'h5A;
   endproperty
   a_reply: assert property (p_reply) else $error("wrong fail reply");

   property p_err_pin;
      @(posedge core_clk) disable iff (!rstN)
         s_fail_check ##0 !hostProgMode |-> ##2 !port3Bit7Oe_n_r && !port3Bit7Out_r;
   endproperty
   a_err_pin: assert property (p_err_pin) else $error("error code not started");

   property p_no_jump;
      @(posedge core_clk) disable iff (!rstN)
         bootFail_r |-> state_r != boot_pkg::ST_JUMP && state_r != boot_pkg::ST_RUN;
   endproperty
   a_no_jump: assert property (p_no_jump) else $error("ran after failure");

   property p_lock;
      @(posedge core_clk) disable iff (!rstN)
         codeMoveReq && codeMoveFromExt && lockBitOne && lockBitTwo |=> codeMoveBlocked_r;
   endproperty
   a_lock: assert property (p_lock) else $error("code move not blocked");
endmodule

// *** boot_defines.svh ***
`ifndef BOOT_DEFINES_SVH
`define BOOT_DEFINES_SVH
`define MAP_CTRL_ADDR    8'hD1
`define MAP_CTRL_RESET   8'h00
`define MAP_BIT          3
`define BOOT_SEL_BIT     6
`define BOOT_ENTRY       16'hF800
`define BOOT_ROM_LO      16'hC000
`define BOOT_ROM_HI      16'hFFFF
`define APP_ENTRY        16'h0000
`define IMG_BYTES        15'h4000
`define APP_TOP          14'h3FFC
`define SEC_BYTE_ADDR    14'h3FFD
`define CRC_LO_ADDR      14'h3FFE
`define CRC_HI_ADDR      14'h3FFF
`define CRC_POLY         16'h8408
`define CRC_INIT         16'hFFFF
`define CRC_RESIDUE      16'hF0B8
`define CHAR_PASS        8'h59
`define CHAR_FAIL        8'h5A
`define CHAR_CR          8'h0D
`define CHAR_LF          8'h0A
`define ERR_CODE         8'hAA
`define CLK_MHZ          100
`define COPY_TIME_S      4
`define COPY_CYCLES      (`COPY_TIME_S * `CLK_MHZ * 1000000)
`define ERR_BIT_CYCLES   8'h10
`define FIFO_DEPTH       16
`define FIFO_WIDTH       8
`endif

// *** boot_pkg.sv ***
package boot_pkg;
   typedef enum logic [3:0] {
      ST_STRAP  = 4'h0,
      ST_ROMRUN = 4'h1,
      ST_LOAD   = 4'h2,
      ST_CHECK  = 4'h3,
      ST_REPORT = 4'h4,
      ST_ERRSIG = 4'h5,
      ST_JUMP   = 4'h6,
      ST_RUN    = 4'h7,
      ST_HALT   = 4'h8
   } boot_state_t;
endpackage

// *** byte_fifo.sv ***
`timescale 1ns/1ps
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rstN,
   // Fill side
   input  wire logic             inValid,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  inReady,
   output logic                  roomTwo,
   // Drain side
   output logic                  outValid,
   output logic [WIDTH-1:0]      outData,
   input  wire logic             outReady
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wrPtr_r;
   logic [AW-1:0]    rdPtr_r;
   logic [AW:0]      count_r;
   logic [AW:0]      count_nxt;
   logic             push;
   logic             pop;

   assign push      = inValid && inReady;
   assign pop       = outValid && outReady;
   assign count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);
   assign outData   = mem[rdPtr_r];

   always_ff @(posedge clk)
   begin
      if (push)
         mem[wrPtr_r] <= inData;
   end

   // Flags registered so the source sees a clean ready
   always_ff @(posedge clk or negedge rstN)
   begin
      if (!rstN)
      begin
         wrPtr_r  <= '0;
         rdPtr_r  <= '0;
         count_r  <= '0;
         inReady  <= 1'b1;
         roomTwo  <= 1'b1;
         outValid <= 1'b0;
      end
      else
      begin
         wrPtr_r  <= wrPtr_r + AW'(push);
         rdPtr_r  <= rdPtr_r + AW'(pop);
         count_r  <= count_nxt;
         inReady  <= count_nxt != (AW+1)'(DEPTH);
         roomTwo  <= count_nxt <= (AW+1)'(DEPTH - 2);
         outValid <= count_nxt != '0;
      end
   end
endmodule

// *** image_source.sv ***
`timescale 1ns/1ps
`include "boot_defines.svh"
module image_source (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   // Test controls
   input  wire logic        streamOn,
   input  wire logic        corrupt,
   // Image stream
   output logic             srcValid,
   output logic [7:0]       srcData,
   input  wire logic        srcReady_r,
   // Internal EEPROM
   input  wire logic        eepRd_r,
   input  wire logic        eepWe_r,
   input  wire logic [13:0] eepAddr_r,
   output logic             eepRdValid,
   output logic [7:0]       eepRdData,
   output logic             eepBusy,
   // Host reply
   output logic             hostTxReady
);
   logic [7:0]  img [16384];
   logic [14:0] idx;
   logic [13:0] rdAddr;
   logic [2:0]  rdWait;
   logic [4:0]  busyCnt;
   logic [1:0]  gap;
   logic [1:0]  hostCnt;
   logic        pend;
   logic [15:0] crc;

   initial
   begin
      crc = `CRC_INIT;
      for (int i = 0; i < 16384; i++)
      begin
         img[i] = (i < 16381) ? (i[7:0] ^ i[13:6]) : 8'hFF;
         if (i < 16382)
         begin
            crc = crc ^ {8'h00, img[i]};
            repeat (8) crc = crc[0] ? ((crc >> 1) ^ `CRC_POLY) : (crc >> 1);
         end
      end
      img[16382] = ~crc[7:0];
      img[16383] = ~crc[15:8];
   end

   // Idle data is inverted so a stale byte is never mistaken for a fresh one
   assign srcValid    = streamOn && (idx < 15'h4000) && (gap == 2'h0);
   assign srcData     = srcValid ? img[idx[13:0]] : ~img[idx[13:0]];
   assign eepRdValid  = pend && (rdWait == 3'h0);
   assign eepRdData   = eepRdValid ? (img[rdAddr] ^ {7'h00, corrupt && rdAddr == 14'h1234})
                                   : ~img[rdAddr];
   assign eepBusy     = busyCnt != 5'h00;
   assign hostTxReady = hostCnt == 2'h3;

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         idx     <= 15'h0000;
         gap     <= 2'h0;
         pend    <= 1'b0;
         rdWait  <= 3'h0;
         rdAddr  <= 14'h0000;
         busyCnt <= 5'h00;
         hostCnt <= 2'h0;
      end
      else
      begin
         hostCnt <= hostCnt + 2'h1;
         if (srcValid && srcReady_r)
         begin
            idx <= idx + 15'h0001;
            gap <= (idx[3:0] == 4'hF) ? 2'h3 : 2'h0;
         end
         else if (gap != 2'h0)
            gap <= gap - 2'h1;
         if (eepRd_r)
         begin
            pend   <= 1'b1;
            rdAddr <= eepAddr_r;
            rdWait <= (eepAddr_r[7:0] == 8'h00) ? 3'h4 : 3'h0;
         end
         else if (pend)
         begin
            pend   <= rdWait != 3'h0;
            rdWait <= rdWait - 3'h1;
         end
         // Long stall lets the buffer fill up
         if (eepWe_r && eepAddr_r[9:0] == 10'h3FF)
            busyCnt <= 5'h18;
         else if (eepBusy)
            busyCnt <= busyCnt - 5'h01;
      end
   end
endmodule

// *** code_ram_boot_and_memory_map_bench.sv ***
`timescale 1ns/1ps
`include "boot_defines.svh"
module code_ram_boot_and_memory_map_bench;
   typedef struct packed {
      logic [7:0] wr;
      logic [6:0] stim;
      logic [7:0] rd;
      logic [4:0] resp;
   } row_t;
   row_t rows [6] = '{
      '{8'h08, 7'b1011111, 8'h08, 5'b10011}, '{8'h08, 7'b1101111, 8'h08, 5'b10000},
      '{8'h00, 7'b1010110, 8'h00, 5'b01000}, '{8'h00, 7'b1111110, 8'h00, 5'b00110},
      '{8'h08, 7'b0111011, 8'h08, 5'b00001}, '{8'h00, 7'b1001000, 8'h00, 5'b01000}};
   logic [7:0]  replyExp [3] = '{`CHAR_PASS, `CHAR_CR, `CHAR_LF};
   logic        core_clk = 1'b0, rst_n = 1'b0, sfrWr = 1'b0, lockBitOne = 1'b0;
   logic        lockBitTwo = 1'b0, externalAccessPin = 1'b1, hostProgMode = 1'b0;
   logic        extSourceDetected = 1'b0, movxReq = 1'b0, extRamSel = 1'b0;
   logic        codeMoveReq = 1'b0, codeMoveFromExt = 1'b0, progReadReq = 1'b0;
   logic        streamOn = 1'b0, corrupt = 1'b0, checkData = 1'b0;
   logic [7:0]  sfrAddr = 8'h00, sfrWrData = 8'h00, cfgByte = 8'h00, code = `ERR_CODE;
   logic [7:0]  sfrRdData_r, srcData, eepRdData, eepWrData_r, pramData_r, hostTxData_r;
   logic [13:0] eepAddr_r, pramAddr_r;
   logic [15:0] pcValue_r;
   logic        movxToProgRam_r, movxToXram_r, movxToExternal_r, codeMoveBlocked_r;
   logic        progReadDenied_r, extAccessLatched_r, srcValid, srcReady_r, eepRd_r;
   logic        eepWe_r, eepRdValid, eepBusy, pramWe_r, pcLoad_r, hostTxValid_r;
   logic        hostTxReady, port3Bit7Out_r, port3Bit7Oe_n_r, bootFail_r;
   logic        jumped0, sawRefuse;
   logic [7:0]  hostQ [$];
   int          n_errors = 0, comparisons = 0, nPram, nEep;

   always #5 core_clk = ~core_clk;

   boot_control #(.COPY_CYCLES(80000)) DUT (.core_clk(core_clk), .rst_n(rst_n),
      .sfrAddr(sfrAddr), .sfrWr(sfrWr), .sfrWrData(sfrWrData), .sfrRdData_r(sfrRdData_r),
      .cfgByte(cfgByte), .lockBitOne(lockBitOne), .lockBitTwo(lockBitTwo),
      .externalAccessPin(externalAccessPin), .hostProgMode(hostProgMode),
      .extSourceDetected(extSourceDetected), .movxReq(movxReq), .extRamSel(extRamSel),
      .movxToProgRam_r(movxToProgRam_r), .movxToXram_r(movxToXram_r),
      .movxToExternal_r(movxToExternal_r), .codeMoveReq(codeMoveReq),
      .codeMoveFromExt(codeMoveFromExt), .progReadReq(progReadReq),
      .codeMoveBlocked_r(codeMoveBlocked_r), .progReadDenied_r(progReadDenied_r),
      .extAccessLatched_r(extAccessLatched_r), .srcValid(srcValid), .srcData(srcData),
      .srcReady_r(srcReady_r), .eepRd_r(eepRd_r), .eepWe_r(eepWe_r), .eepAddr_r(eepAddr_r),
      .eepWrData_r(eepWrData_r), .eepRdValid(eepRdValid), .eepRdData(eepRdData),
      .eepBusy(eepBusy), .pramWe_r(pramWe_r), .pramAddr_r(pramAddr_r),
      .pramData_r(pramData_r), .pcLoad_r(pcLoad_r), .pcValue_r(pcValue_r),
      .hostTxValid_r(hostTxValid_r), .hostTxData_r(hostTxData_r), .hostTxReady(hostTxReady),
      .port3Bit7Out_r(port3Bit7Out_r), .port3Bit7Oe_n_r(port3Bit7Oe_n_r),
      .bootFail_r(bootFail_r));

   image_source P (.core_clk(core_clk), .rst_n(rst_n), .streamOn(streamOn),
      .corrupt(corrupt), .srcValid(srcValid), .srcData(srcData), .srcReady_r(srcReady_r),
      .eepRd_r(eepRd_r), .eepWe_r(eepWe_r), .eepAddr_r(eepAddr_r), .eepRdValid(eepRdValid),
      .eepRdData(eepRdData), .eepBusy(eepBusy), .hostTxReady(hostTxReady));

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk_byte(logic [7:0] got, logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_word(logic [15:0] got, logic [15:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Bounded wait: 0 for a program counter load, 1 for the error pin driving
   task automatic wait_for(logic pin, int lim);
      int i;
      for (i = 0; i < lim; i++)
      begin
         @(posedge core_clk);
         #1;
         if (pin ? port3Bit7Oe_n_r === 1'b0 : pcLoad_r === 1'b1)
            break;
      end
      if (i == lim)
      begin
         n_errors++;
         wrap_up();
      end
   endtask

   task automatic boot(logic [7:0] cfg, logic host, logic ext, logic [15:0] pc);
      @(posedge core_clk);
      rst_n <= 1'b0;
      streamOn <= 1'b0;
      {cfgByte, hostProgMode, extSourceDetected} <= {cfg, host, ext};
      repeat (8) @(posedge core_clk);
      chk_word(pcValue_r, `BOOT_ENTRY);
      chk_byte({6'h00, port3Bit7Oe_n_r, port3Bit7Out_r}, 8'h03);
      {nPram, nEep, jumped0, sawRefuse} = '0;
      hostQ.delete();
      rst_n <= 1'b1;
      wait_for(1'b0, 10);
      chk_word(pcValue_r, pc);
   endtask

   task automatic sfr_wr(logic [7:0] a, logic [7:0] d);
      @(posedge core_clk);
      {sfrAddr, sfrWrData, sfrWr} <= {a, d, 1'b1};
      @(posedge core_clk);
      sfrWr <= 1'b0;
      sfrAddr <= `MAP_CTRL_ADDR;
   endtask

   always @(posedge core_clk)
   begin
      if (pramWe_r)
      begin
         chk_word({2'b00, pramAddr_r}, nPram[15:0]);
         if (checkData)
            chk_byte(pramData_r, P.img[pramAddr_r]);
         nPram++;
      end
      if (eepWe_r)
      begin
         nEep++;
         chk_byte(eepWrData_r, P.img[eepAddr_r]);
      end
      if (hostTxValid_r && hostTxReady)
         hostQ.push_back(hostTxData_r);
      if (pcLoad_r && pcValue_r === `APP_ENTRY)
         jumped0 = 1'b1;
      if (srcValid && !srcReady_r && streamOn)
         sawRefuse = 1'b1;
   end

   initial
   begin
      repeat (100000) @(posedge core_clk);
      n_errors++;
      wrap_up();
   end

   initial
   begin
      boot(8'h40, 1'b0, 1'b0, `APP_ENTRY);
      foreach (rows[k])
      begin
         sfr_wr(`MAP_CTRL_ADDR, rows[k].wr);
         {movxReq, extRamSel, lockBitOne, lockBitTwo} <= rows[k].stim[6:3];
         {progReadReq, codeMoveReq, codeMoveFromExt} <= rows[k].stim[2:0];
         @(posedge core_clk);
         #1;
         chk_byte(sfrRdData_r, rows[k].rd);
         chk_byte({3'h0, movxToProgRam_r, movxToXram_r, movxToExternal_r, progReadDenied_r,
            codeMoveBlocked_r}, {3'h0, rows[k].resp});
      end
      sfr_wr(`MAP_CTRL_ADDR, 8'h08);
      sfr_wr(8'hD2, 8'h00);
      externalAccessPin <= 1'b0;
      @(posedge core_clk);
      #1;
      chk_byte(sfrRdData_r, 8'h08);
      chk_byte({7'h00, extAccessLatched_r}, 8'h01);
      @(posedge core_clk);
      sfrAddr <= 8'hD0;
      @(posedge core_clk);
      sfrAddr <= `MAP_CTRL_ADDR;
      #1;
      chk_byte(sfrRdData_r, 8'h00);
      $display("test map and lock done");
      boot(8'h00, 1'b1, 1'b1, `BOOT_ENTRY);
      @(posedge core_clk);
      #1;
      chk_byte(sfrRdData_r, `MAP_CTRL_RESET);
      streamOn <= 1'b1;
      checkData <= 1'b1;
      wait_for(1'b0, 90000);
      chk_word(pcValue_r, `APP_ENTRY);
      chk_word(nPram[15:0], {1'b0, `IMG_BYTES});
      chk_word(nEep[15:0], {1'b0, `IMG_BYTES});
      chk_byte({7'h00, sawRefuse}, 8'h01);
      for (int k = 0; k < 3; k++)
         chk_byte(hostQ[k], replyExp[k]);
      chk_byte({7'h00, bootFail_r}, 8'h00);
      $display("test host load done");
      boot(8'h00, 1'b0, 1'b1, `BOOT_ENTRY);
      streamOn <= 1'b1;
      wait_for(1'b0, 30000);
      chk_word(pcValue_r, `APP_ENTRY);
      $display("test download pass done");
      checkData <= 1'b0;
      corrupt <= 1'b1;
      boot(8'h00, 1'b0, 1'b0, `BOOT_ENTRY);
      wait_for(1'b1, 90000);
      chk_word(nPram[15:0], {1'b0, `IMG_BYTES});
      repeat (`ERR_BIT_CYCLES / 2) @(posedge core_clk);
      for (int b = 0; b < 9; b++)
      begin
         #1;
         chk_byte({7'h00, port3Bit7Out_r}, {7'h00, b == 8 || code[b]});
         repeat (`ERR_BIT_CYCLES) @(posedge core_clk);
      end
      repeat (200) @(posedge core_clk);
      #1;
      chk_byte({6'h00, bootFail_r, jumped0}, 8'h02);
      $display("test download failure done");
      wrap_up();
   end
endmodule
